/* t16_pkg.sv */
// constants, carriers and state layouts of the 16-bit timer with prescaler and gate
// Behaviour
// (R1) Prescaler divides the selected clock by 1, 2, 4 or 8 from control bits 5:4.
// (R2) Prescale field value 11 divides the counter clock by eight.
// (R3) Prescaler is hidden from software; writing either count byte clears it.
// (R4) Gate enable ignored when off; when on and set, count only while gate low.
// (R5) When on with gate enable clear, count regardless of the gate pin.
// (R6) Oscillator enable bit 3 acts only with internal oscillator without clock output.
// (R7) External source: bit 2 set means unsynchronised, clear means synchronised; else ignored.
// (R8) Bit 1 selects external pin rising edges, or the internal instruction clock.
// (R9) Timer mode increments once per instruction cycle, after prescaling.
// (R10) Counting only while control bit 0 is set; stopped while clear.
// (R11) External mode: first rising edge counts only after a falling edge was seen.
// (R12) Control bit 7 is unimplemented and reads as zero.
// (R13) Sync control set passes the external clock without synchronising to instruction phases.
// (R14) Asynchronous counter mode keeps running in sleep; overflow can wake the core.
// (R15) Rollover from ffff to zero sets the overflow flag, status bit 0.
// (R16) Reset clears every implemented control bit: stopped, internal clock, divide by one.
package t16_pkg;

   // register byte addresses
   localparam logic [7:0] ADDR_CONTROL  = 8'h10;
   localparam logic [7:0] ADDR_COUNT_LO = 8'h14;
   localparam logic [7:0] ADDR_COUNT_HI = 8'h18;
   localparam logic [7:0] ADDR_IRQ_STS  = 8'h1c;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
   localparam logic [7:0] ADDR_STATE    = 8'h24;

   // control and interrupt field positions
   localparam int BIT_TIMER_ON  = 0;
   localparam int BIT_CLK_SRC   = 1;
   localparam int BIT_NO_SYNC   = 2;
   localparam int BIT_OSC_EN    = 3;
   localparam int BIT_PS_LO     = 4;
   localparam int BIT_PS_HI     = 5;
   localparam int BIT_GATE_EN   = 6;
   localparam int BIT_OVERFLOW  = 0;

   // reset values and counts
   localparam logic [6:0]  CONTROL_RESET = 7'h00;
   localparam logic [15:0] COUNT_MAX     = 16'hffff;
   localparam logic [1:0]  INSTR_LAST    = 2'h3;
   localparam logic [1:0]  PS_DIV8       = 2'h3;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } t16_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } t16_wb_rsp_t;

   typedef struct packed {
      logic [2:0] cnt;
      logic       pulse;
   } t16_ps_state_t;

   typedef struct packed {
      logic [6:0]  ctrl;
      logic [15:0] count;
      logic [2:0]  gate_s;
      logic [2:0]  ext_s;
      logic        gate_lvl;
      logic        ext_lvl;
      logic        armed;
      logic [1:0]  div;
      logic        ovf_sts;
      logic        ovf_mask;
      logic        irq;
      logic        wake;
      logic        osc_run;
      t16_wb_rsp_t rsp;
   } t16_state_t;

   // terminal count mask of the prescaler for a given ratio select
   function automatic logic [2:0] ps_mask(input logic [1:0] sel);
      case (sel)
         2'h0:    ps_mask = 3'h0;
         2'h1:    ps_mask = 3'h1;
         2'h2:    ps_mask = 3'h3;
         default: ps_mask = 3'h7; // R2
      endcase
   endfunction

endpackage

/* t16_prescale.sv */
// prescaler ahead of the 16-bit counter
`timescale 1ns/1ps
`default_nettype none
module t16_prescale (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // control
   input  wire logic       clear_i,
   input  wire logic       tick_i,
   input  wire logic [1:0] sel_i,
   // divided tick
   output logic            pulse_o
);

   t16_pkg::t16_ps_state_t st_ff;
   t16_pkg::t16_ps_state_t nxt_st;
   logic                   at_end;

   always_comb
   begin
      nxt_st       = st_ff;
      nxt_st.pulse = 1'b0;
      at_end       = ((st_ff.cnt & t16_pkg::ps_mask(sel_i)) == t16_pkg::ps_mask(sel_i));
      if (clear_i)
      begin
         nxt_st.cnt = 3'h0; // R3
      end
      else if (tick_i)
      begin
         if (at_end)
         begin
            nxt_st.cnt   = 3'h0; // R1
            nxt_st.pulse = 1'b1;
         end
         else
         begin
            nxt_st.cnt = st_ff.cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign pulse_o = st_ff.pulse;

   a_clear_empties: assert property (@(posedge clk_i) disable iff (rst_i) // R3
      clear_i |=> (st_ff.cnt == 3'h0) && !pulse_o)
      else $error("prescaler not emptied by count write");

   a_div_one_pass: assert property (@(posedge clk_i) disable iff (rst_i) // R1
      (sel_i == 2'h0 && tick_i && !clear_i) |=> pulse_o)
      else $error("divide by one lost a tick");

   a_div_eight_end: assert property (@(posedge clk_i) disable iff (rst_i) // R2
      (sel_i == t16_pkg::PS_DIV8 && tick_i && !clear_i) |=> (pulse_o == ($past(st_ff.cnt) == 3'h7)))
      else $error("divide by eight pulse at wrong count");

endmodule
`default_nettype wire

/* t16_timer.sv */
// 16-bit timer/counter with prescaler, gate and wishbone register access
`timescale 1ns/1ps
`default_nettype none
module t16_timer (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // wishbone slave
   input  wire t16_pkg::t16_wb_req_t wb_req_i,
   output t16_pkg::t16_wb_rsp_t      wb_rsp_o,
   // pins
   input  wire logic                 external_clock_pin_i,
   input  wire logic                 gate_pin_n_i,
   // system
   input  wire logic                 sleep_i,
   input  wire logic                 internal_oscillator_i,
   output logic                      lp_osc_run_o,
   output logic                      irq_o,
   output logic                      wake_o
);

   t16_pkg::t16_state_t st_ff;
   t16_pkg::t16_state_t nxt_st;

   logic       req;
   logic       wr;
   logic       cnt_wr;
   logic       ext_rise;
   logic       ext_fall;
   logic       gate_ok;
   logic       may_run;
   logic       instr_tick;
   logic       src_tick;
   logic       pre_tick;
   logic       ps_pulse;
   logic       inc;
   logic       ovf;
   logic [7:0] rd_byte;
   logic [7:0] adr;
   logic [7:0] wdat;

   t16_prescale u_prescale (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .clear_i (cnt_wr),
      .tick_i  (pre_tick),
      .sel_i   (st_ff.ctrl[t16_pkg::BIT_PS_HI:t16_pkg::BIT_PS_LO]),
      .pulse_o (ps_pulse)
   );

   always_comb
   begin
      nxt_st = st_ff;
      adr    = {wb_req_i.adr[7:2], 2'h0};
      wdat   = wb_req_i.dat[7:0];
      req    = wb_req_i.cyc && wb_req_i.stb && !st_ff.rsp.ack;
      wr     = req && wb_req_i.we && wb_req_i.sel[0];
      cnt_wr = wr && (adr == t16_pkg::ADDR_COUNT_LO || adr == t16_pkg::ADDR_COUNT_HI);

      // pins pass three flops; a level is taken once the last two agree
      nxt_st.gate_s = {st_ff.gate_s[1:0], gate_pin_n_i};
      nxt_st.ext_s  = {st_ff.ext_s[1:0], external_clock_pin_i};
      if (st_ff.gate_s[1] == st_ff.gate_s[2])
      begin
         nxt_st.gate_lvl = st_ff.gate_s[2];
      end
      ext_rise = (st_ff.ext_s[1] == st_ff.ext_s[2]) && st_ff.ext_s[2] && !st_ff.ext_lvl;
      ext_fall = (st_ff.ext_s[1] == st_ff.ext_s[2]) && !st_ff.ext_s[2] && st_ff.ext_lvl;
      if (st_ff.ext_s[1] == st_ff.ext_s[2])
      begin
         nxt_st.ext_lvl = st_ff.ext_s[2];
      end

      // instruction cycle is four system clocks
      nxt_st.div = st_ff.div + 2'h1;
      instr_tick = (st_ff.div == t16_pkg::INSTR_LAST);

      // a falling edge must be seen after enable before any rising edge counts
      if (!st_ff.ctrl[t16_pkg::BIT_TIMER_ON] || !st_ff.ctrl[t16_pkg::BIT_CLK_SRC])
      begin
         nxt_st.armed = 1'b0; // R11
      end
      else if (ext_fall)
      begin
         nxt_st.armed = 1'b1; // R11
      end

      gate_ok = !st_ff.ctrl[t16_pkg::BIT_GATE_EN] || !st_ff.gate_lvl; // R4 R5
      // synchronised and timer modes halt in sleep; only the unsynchronised counter runs on
      may_run = st_ff.ctrl[t16_pkg::BIT_TIMER_ON] && gate_ok // R10
                && (!sleep_i || (st_ff.ctrl[t16_pkg::BIT_CLK_SRC] && st_ff.ctrl[t16_pkg::BIT_NO_SYNC])); // R7 R13 R14
      src_tick = st_ff.ctrl[t16_pkg::BIT_CLK_SRC] ? (ext_rise && st_ff.armed) : instr_tick; // R8 R9 R11
      pre_tick = may_run && src_tick;

      inc = ps_pulse && st_ff.ctrl[t16_pkg::BIT_TIMER_ON]; // R10
      ovf = 1'b0;
      if (cnt_wr)
      begin
         if (adr == t16_pkg::ADDR_COUNT_LO)
         begin
            nxt_st.count[7:0] = wdat;
         end
         else
         begin
            nxt_st.count[15:8] = wdat;
         end
      end
      else if (inc)
      begin
         nxt_st.count = st_ff.count + 16'h1;
         ovf          = (st_ff.count == t16_pkg::COUNT_MAX); // R15
      end

      // register writes
      if (wr)
      begin
         case (adr)
            t16_pkg::ADDR_CONTROL:
            begin
               nxt_st.ctrl = wdat[6:0];
            end
            t16_pkg::ADDR_IRQ_MASK:
            begin
               nxt_st.ovf_mask = wdat[t16_pkg::BIT_OVERFLOW];
            end
            t16_pkg::ADDR_IRQ_STS:
            begin
               if (wdat[t16_pkg::BIT_OVERFLOW])
               begin
                  nxt_st.ovf_sts = 1'b0;
               end
            end
            default:
            begin
               nxt_st.ctrl = st_ff.ctrl;
            end
         endcase
      end
      // a rollover in the clearing cycle still sets the flag
      if (ovf)
      begin
         nxt_st.ovf_sts = 1'b1; // R15
      end
      nxt_st.irq  = nxt_st.ovf_sts && nxt_st.ovf_mask;
      nxt_st.wake = ovf && sleep_i && nxt_st.ovf_mask; // R14

      // oscillator bit is honoured only on the internal oscillator
      nxt_st.osc_run = internal_oscillator_i && st_ff.ctrl[t16_pkg::BIT_OSC_EN]; // R6

      // reads
      case (adr)
         t16_pkg::ADDR_CONTROL:  rd_byte = {1'b0, st_ff.ctrl}; // R12
         t16_pkg::ADDR_COUNT_LO: rd_byte = st_ff.count[7:0];
         t16_pkg::ADDR_COUNT_HI: rd_byte = st_ff.count[15:8];
         t16_pkg::ADDR_IRQ_STS:  rd_byte = {7'h00, st_ff.ovf_sts};
         t16_pkg::ADDR_IRQ_MASK: rd_byte = {7'h00, st_ff.ovf_mask};
         t16_pkg::ADDR_STATE:    rd_byte = {4'h0, may_run, st_ff.gate_lvl, st_ff.armed, st_ff.osc_run};
         default:                rd_byte = 8'h00;
      endcase
      nxt_st.rsp.ack = req;
      nxt_st.rsp.dat = (req && !wb_req_i.we) ? {24'h000000, rd_byte} : 32'h00000000;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_ff          <= '0;
         st_ff.ctrl     <= t16_pkg::CONTROL_RESET; // R16
         // gate pin idles high; starting there keeps the gate from looking open after reset
         st_ff.gate_s   <= '1;
         st_ff.gate_lvl <= 1'b1;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign wb_rsp_o     = st_ff.rsp;
   assign irq_o        = st_ff.irq;
   assign wake_o       = st_ff.wake;
   assign lp_osc_run_o = st_ff.osc_run;

   a_reset_ctrl_zero: assert property (@(posedge clk_i) // R16
      rst_i |=> (st_ff.ctrl == 7'h00) && !irq_o)
      else $error("control not cleared by reset");

   a_reserved_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i) // R12
      (req && !wb_req_i.we && adr == t16_pkg::ADDR_CONTROL)
      |=> wb_rsp_o.ack && (wb_rsp_o.dat[7:0] == {1'b0, $past(st_ff.ctrl)}))
      else $error("control read wrong or bit 7 set");

   a_off_holds_count: assert property (@(posedge clk_i) disable iff (rst_i) // R10
      (!st_ff.ctrl[t16_pkg::BIT_TIMER_ON] && !cnt_wr) |=> (st_ff.count == $past(st_ff.count)))
      else $error("count moved while timer off");

   a_gate_blocks_count: assert property (@(posedge clk_i) disable iff (rst_i) // R4
      (st_ff.ctrl[t16_pkg::BIT_GATE_EN] && st_ff.gate_lvl) |-> !pre_tick)
      else $error("count advanced with gate high");

   a_gate_ignored_off: assert property (@(posedge clk_i) disable iff (rst_i) // R5
      (st_ff.ctrl[t16_pkg::BIT_TIMER_ON] && !st_ff.ctrl[t16_pkg::BIT_GATE_EN]
       && !st_ff.ctrl[t16_pkg::BIT_CLK_SRC] && instr_tick && !sleep_i) |-> pre_tick)
      else $error("instruction tick lost with gate disabled");

   a_first_rise_armed: assert property (@(posedge clk_i) disable iff (rst_i) // R11
      (st_ff.ctrl[t16_pkg::BIT_CLK_SRC] && !st_ff.armed) |-> !pre_tick)
      else $error("rising edge counted before a falling edge");

   a_sync_sleep_stops: assert property (@(posedge clk_i) disable iff (rst_i) // R7
      (sleep_i && !st_ff.ctrl[t16_pkg::BIT_NO_SYNC]) |-> !pre_tick)
      else $error("synchronised count ran during sleep");

   a_async_sleep_runs: assert property (@(posedge clk_i) disable iff (rst_i) // R14
      (sleep_i && st_ff.ctrl[t16_pkg::BIT_TIMER_ON] && st_ff.ctrl[t16_pkg::BIT_CLK_SRC]
       && st_ff.ctrl[t16_pkg::BIT_NO_SYNC] && gate_ok && ext_rise && st_ff.armed) |-> pre_tick)
      else $error("asynchronous count stopped in sleep");

   a_overflow_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R15
      (inc && !cnt_wr && st_ff.count == t16_pkg::COUNT_MAX)
      |=> st_ff.ovf_sts && (st_ff.count == 16'h0000))
      else $error("rollover did not set overflow flag");

   a_osc_needs_internal_oscillator: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      !internal_oscillator_i |=> !lp_osc_run_o)
      else $error("oscillator run without internal oscillator");

endmodule
`default_nettype wire

/* t16_pin_src.sv */
// external count clock and gate pin source for the timer bench
`timescale 1ns/1ps
`default_nettype none
module t16_pin_src (
   // clock
   input  wire logic clk_i,
   // pins
   output var logic  ext_o,
   output var logic  gate_n_o
);
   initial
   begin
      ext_o    = 1'b0;
      gate_n_o = 1'b1;
   end
   // clock stands still between bursts; each level is held long enough for the sync flops
   task automatic burst(input int n, input int half);
      repeat (n)
      begin
         ext_o <= 1'b1;
         repeat (half) @(posedge clk_i);
         ext_o <= 1'b0;
         repeat (half) @(posedge clk_i);
      end
   endtask
   task automatic gate(input logic lvl);
      gate_n_o <= lvl;
      @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

/* t16_tb.sv */
// self-checking bench of the 16-bit timer with prescaler and gate
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic                 clk_i;
   logic                 rst_i;
   logic                 sleep_i;
   logic                 int_osc;
   logic                 lp_osc;
   logic                 irq;
   logic                 wake;
   logic                 ext_pin;
   logic                 gate_pin_n;
   logic [7:0]           r;
   logic [7:0]           q;
   logic [15:0]          cnt;
   t16_pkg::t16_wb_req_t req;
   t16_pkg::t16_wb_rsp_t rsp;
   int                   n_fail;
   int                   n_compared;
   int                   n_wake;
   int                   seed;
   int                   k;
   t16_pin_src src (.clk_i(clk_i), .ext_o(ext_pin), .gate_n_o(gate_pin_n));
   t16_timer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
      .external_clock_pin_i(ext_pin), .gate_pin_n_i(gate_pin_n), .sleep_i(sleep_i),
      .internal_oscillator_i(int_osc), .lp_osc_run_o(lp_osc), .irq_o(irq), .wake_o(wake));
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (wake === 1'b1) n_wake++;
   task automatic give_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      give_verdict();
   end
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] rd);
      req <= '{1'b1, 1'b1, we, a, 4'h1, {24'h0, d}};
      do @(posedge clk_i); while (rsp.ack !== 1'b1);
      rd = rsp.dat[7:0];
      req <= '0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, d, q);
   endtask
   task automatic rdc(output logic [15:0] c);
      wb(1'b0, t16_pkg::ADDR_COUNT_LO, 8'h00, c[7:0]);
      wb(1'b0, t16_pkg::ADDR_COUNT_HI, 8'h00, c[15:8]);
   endtask
   // clear count, run with ctl for a span or an external burst, stop, read back
   task automatic run(input logic [7:0] ctl, input int clks, input int n, output logic [15:0] c);
      wr(t16_pkg::ADDR_COUNT_LO, 8'h00);
      wr(t16_pkg::ADDR_COUNT_HI, 8'h00);
      wr(t16_pkg::ADDR_CONTROL, ctl);
      if (n > 0) src.burst(n, 3 + $unsigned($random(seed)) % 3);
      repeat (clks) @(posedge clk_i);
      wr(t16_pkg::ADDR_CONTROL, ctl & 8'hfe);
      rdc(c);
   endtask
   function automatic logic near(input logic [15:0] c, input int clks, input int ps);
      int e;
      e = clks / (4 << ps);
      return (c + 1 >= e) && (c <= e + 1);
   endfunction
   initial
   begin
      seed = 16165;
      n_fail = 0;
      n_compared = 0;
      rst_i = 1'b1;
      sleep_i = 1'b0;
      int_osc = 1'b0;
      req = '0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, t16_pkg::ADDR_CONTROL, 8'h00, r);
      chk("ctrl reset", r, 0);
      wb(1'b0, 8'h3c, 8'h00, r);
      chk("unmapped", r, 0);
      repeat (6)
      begin
         k = $random(seed);
         wr(t16_pkg::ADDR_CONTROL, k[7:0] | 8'h80);
         wb(1'b0, t16_pkg::ADDR_CONTROL, 8'h00, r);
         chk("ctrl readback", r, {1'b0, k[6:0]});
      end
      // reset in mid-run must drop whatever the random writes left behind
      rst_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, t16_pkg::ADDR_CONTROL, 8'h00, r);
      chk("ctrl mid reset", r, 0);
      $display("test registers done");
      for (int ps = 0; ps < 4; ps++)
      begin
         k = (3 + $unsigned($random(seed)) % 4) * (4 << ps);
         run({2'h0, ps[1:0], 4'h1}, k, 0, cnt);
         chk("timer count", near(cnt, k, ps), 1);
         k = 1 + $unsigned($random(seed)) % 12;
         run({2'h0, ps[1:0], 4'h3}, 8, k, cnt);
         chk("ext count", cnt, (k - 1) >> ps);
      end
      run(8'h05, 64, 0, cnt);
      chk("sync ignored", near(cnt, 64, 0), 1);
      $display("test prescale done");
      src.gate(1'b1);
      wr(t16_pkg::ADDR_CONTROL, 8'h41);
      wb(1'b0, t16_pkg::ADDR_STATE, 8'h00, r);
      chk("state gated", r, 8'h04);
      run(8'h41, 64, 0, cnt);
      chk("gate high", cnt, 0);
      run(8'h01, 64, 0, cnt);
      chk("gate off", near(cnt, 64, 0), 1);
      src.gate(1'b0);
      wr(t16_pkg::ADDR_CONTROL, 8'h41);
      wb(1'b0, t16_pkg::ADDR_STATE, 8'h00, r);
      chk("state open", r, 8'h08);
      run(8'h41, 64, 0, cnt);
      chk("gate low", near(cnt, 64, 0), 1);
      run(8'h40, 64, 0, cnt);
      chk("timer off", cnt, 0);
      $display("test gate done");
      run(8'h33, 0, 0, cnt);
      wr(t16_pkg::ADDR_CONTROL, 8'h33);
      src.burst(6, 3);
      wr(t16_pkg::ADDR_COUNT_LO, 8'h00);
      src.burst(3, 4);
      rdc(cnt);
      chk("ps cleared", cnt, 0);
      src.burst(5, 3);
      rdc(cnt);
      chk("ps resumed", cnt, 1);
      $display("test prescale clear done");
      sleep_i <= 1'b1;
      run(8'h03, 8, 5, cnt);
      chk("sync sleep", cnt, 0);
      run(8'h07, 8, 5, cnt);
      chk("async sleep", cnt, 4);
      wr(t16_pkg::ADDR_COUNT_LO, 8'hff);
      wr(t16_pkg::ADDR_COUNT_HI, 8'hff);
      wr(t16_pkg::ADDR_IRQ_MASK, 8'h01);
      wr(t16_pkg::ADDR_IRQ_STS, 8'h01);
      n_wake = 0;
      wr(t16_pkg::ADDR_CONTROL, 8'h07);
      src.burst(3, 3);
      repeat (8) @(posedge clk_i);
      chk("wake", n_wake, 1);
      rdc(cnt);
      chk("rollover", cnt, 1);
      wb(1'b0, t16_pkg::ADDR_IRQ_STS, 8'h00, r);
      chk("ovf flag", r, 1);
      chk("irq", irq, 1);
      wr(t16_pkg::ADDR_IRQ_MASK, 8'h00);
      repeat (2) @(posedge clk_i);
      chk("irq masked", irq, 0);
      wr(t16_pkg::ADDR_IRQ_STS, 8'h01);
      wb(1'b0, t16_pkg::ADDR_IRQ_STS, 8'h00, r);
      chk("ovf cleared", r, 0);
      sleep_i <= 1'b0;
      $display("test overflow done");
      for (int i = 0; i < 4; i++)
      begin
         int_osc <= i[0];
         wr(t16_pkg::ADDR_CONTROL, {4'h0, i[1], 3'h0});
         repeat (2) @(posedge clk_i);
         chk("lp osc", lp_osc, i[0] & i[1]);
      end
      $display("test oscillator done");
      give_verdict();
   end
endmodule
`default_nettype wire
